// file: logic/ubc_pkg.sv
// Constants, types and register map of the baud-rate calibrator
package ubc_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  // Register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CLEAR = 8'h04;
  localparam logic [7:0] OFS_ENABLE = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_DIVIDER = 8'h10;
  localparam logic [7:0] OFS_CAPTURE = 8'h14;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  // Event bit positions
  localparam int unsigned EV_TICK = 0;
  localparam int unsigned EV_DONE = 1;
  localparam int unsigned EV_RX = 2;
  localparam int unsigned EV_RXERR = 3;
  localparam int unsigned EV_W = 4;
  localparam int unsigned CTRL_CAL_EN = 0;
  localparam logic CTRL_RESET_VAL = 1'b1;
  // Interval tick
  localparam int unsigned IVAL_PRESCALE = 64;
  localparam logic [7:0] IVAL_COMPARE = 8'hE9;
  // Waveform generator and measurement
  localparam logic [15:0] HALF_RELOAD = 16'h1296;
  localparam int unsigned MAX_DIVISOR = 9516;
  localparam logic [1:0] MEAS_EVENTS = 2'h2;
  localparam logic [14:0] FIELD_NUMERATOR = 15'h5AC0;
  localparam int unsigned FIELD_LSB = 9;
  localparam int unsigned FIELD_W = 7;
  // Serial link: 8 data bits, LSB first, even parity
  localparam int unsigned UART_CLK_HZ = 2_000_000;
  localparam int unsigned BAUD = 9600;
  localparam logic [6:0] NOMINAL_FIELD = 7'(UART_CLK_HZ / (2 * BAUD) - 1);
  localparam logic [15:0] DIVIDER_RESET = {NOMINAL_FIELD, 9'h000};
  // High-speed oscillator settling time
  localparam int unsigned HSO_STAB_NS = 10000;
  localparam int unsigned HSO_STAB_CYC = (HSO_STAB_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Received characters and error kinds
  localparam logic [7:0] CHAR_UPPER_T = 8'h54;
  localparam logic [7:0] CHAR_LOWER_T = 8'h74;
  localparam logic [1:0] ERR_PARITY = 2'h0;
  localparam logic [1:0] ERR_FRAMING = 2'h1;

  typedef enum logic [2:0] {
    RP_OK_UPPER = 3'b000,
    RP_OK_LOWER = 3'b001,
    RP_UNKNOWN = 3'b010,
    RP_PARITY = 3'b011,
    RP_FRAMING = 3'b100,
    RP_OVERRUN = 3'b101
  } ubc_reply_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_STOP_UART = 4'b0001,
    ST_STAB = 4'b0010,
    ST_SWITCH_HI = 4'b0011,
    ST_MEASURE = 4'b0100,
    ST_DIVIDE = 4'b0101,
    ST_WRITE = 4'b0110,
    ST_SWITCH_LO = 4'b0111,
    ST_RESTART = 4'b1000
  } ubc_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ubc_bus_req_t;
endpackage

// file: logic/ubc_udiv.sv
// Serial restoring unsigned divider
`timescale 1ns/1ns
module ubc_udiv
  import ubc_pkg::*;
#(
  parameter int unsigned NUM_W = 15,
  parameter int unsigned DEN_W = 8
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [NUM_W-1:0] numerator,
  input wire logic [DEN_W-1:0] denominator,
  output logic done,
  output logic [NUM_W-1:0] quotient
);
  localparam int unsigned CNT_W = $clog2(NUM_W + 1);
  localparam logic [CNT_W-1:0] STEPS = CNT_W'(NUM_W);

  logic [DEN_W-1:0] rem_q;
  logic [CNT_W-1:0] cnt_q;
  logic busy_q;
  logic [DEN_W:0] trial;

  initial
  begin
    if (NUM_W < 2 || DEN_W < 1)
      $error("ubc_udiv: widths too small");
  end

  assign trial = {rem_q, quotient[NUM_W-1]};

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rem_q <= '0;
      quotient <= '0;
      cnt_q <= '0;
      busy_q <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        rem_q <= '0;
        quotient <= numerator;
        cnt_q <= STEPS;
        busy_q <= 1'b1;
      end
      else if (busy_q)
      begin
        if (trial >= {1'b0, denominator})
        begin
          rem_q <= DEN_W'(trial - {1'b0, denominator});
          quotient <= {quotient[NUM_W-2:0], 1'b1};
        end
        else
        begin
          rem_q <= trial[DEN_W-1:0];
          quotient <= {quotient[NUM_W-2:0], 1'b0};
        end
        cnt_q <= cnt_q - 1'b1;
        if (cnt_q == CNT_W'(1))
        begin
          busy_q <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule

// file: logic/ubc_calibrator.sv
// Periodic baud-rate calibrator for a UART on a low-accuracy oscillator
//
// Operation
// - 8-bit interval counter on low-speed clock /64 matches 0xE9, about once a second.
// - Waveform channel is a 16-bit interval timer giving a positive square wave.
// - Waveform channel counts on falling edges of the mid-speed oscillator.
// - Waveform channel starts on internal trigger, no event at count start.
// - Half-period reload is 4758, full period about 9516 mid cycles.
// - Divisor keeps worst-case measured count within 16 bits; at most 9516.
// - Measuring channel counts the 24 MHz oscillator, pulse-width mode.
// - Rising edge of measure pin starts counting and captures the count.
// - On tick: stop UART, start fast oscillator, wait settling, switch clock high.
// - After second measuring completion event, stop both channels.
// - New divider bits 15:9 = 23232 / upper eight captured bits.
// - UART clock is system clock /2 = 2 MHz; field+1 = clock/(2*9600).
// - After writing divider: clock back to mid oscillator, stop fast one, restart UART.
// - Busy indicator high from correction start until UART restarted.
// - Interval counter halts while a reply is being transmitted.
// - Receive or receive-error event starts a matching reply when no reply is active.
// - Link is 8 data bits, LSB first, even parity, 9600 bit/s.
`timescale 1ns/1ns
module ubc_calibrator
  import ubc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire ubc_bus_req_t bus_req,
  output logic [DATA_W-1:0] rd_data_q,
  output logic irq_q,
  input wire logic low_speed_clk,
  input wire logic mid_speed_osc,
  input wire logic high_speed_osc,
  input wire logic measure_input_pin,
  output logic divided_wave_output,
  output logic high_osc_en_q,
  output logic sys_clk_high_q,
  output logic uart_run_q,
  output logic cal_busy_q,
  output logic [15:0] uart_divider_reg,
  input wire logic rx_complete_event,
  input wire logic rx_error_event,
  input wire logic tx_complete_event,
  input wire logic [7:0] rx_data,
  input wire logic [1:0] rx_err_kind,
  output logic reply_start_q,
  output logic reply_active_q,
  output ubc_reply_t reply_kind_q
);
  localparam int unsigned STAB_W = $clog2(HSO_STAB_CYC + 1);
  localparam logic [STAB_W-1:0] STAB_LAST = STAB_W'(HSO_STAB_CYC - 1);
  localparam logic [5:0] PRESCALE_LAST = 6'(IVAL_PRESCALE - 1);

  initial
  begin
    if (2 * HALF_RELOAD > MAX_DIVISOR)
      $error("ubc_calibrator: divisor above worst-case limit");
  end

  ubc_state_t state_q;
  logic [EV_W-1:0] status_q, enable_q, ev_set;
  logic ctrl_en_q;
  logic low_prev_q, mid_prev_q, high_prev_q, meas_prev_q;
  logic low_rise, mid_fall, high_rise, meas_rise;
  logic [5:0] pre_cnt_q;
  logic [7:0] ival_cnt_q;
  logic ival_evt_q;
  logic [STAB_W-1:0] stab_cnt_q;
  logic gen_run_q;
  logic [15:0] gen_cnt_q;
  logic meas_run_q, meas_started_q;
  logic [15:0] meas_cnt_q, cap_q;
  logic [1:0] evt_cnt_q;
  logic meas_evt;
  logic div_start_q, div_done;
  logic [14:0] div_quo;
  logic [6:0] field_sat;
  logic wr_clear, wr_enable, wr_ctrl;

  // Edge detection on synchronous oscillator and pin inputs
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      low_prev_q <= 1'b0;
      mid_prev_q <= 1'b0;
      high_prev_q <= 1'b0;
      meas_prev_q <= 1'b0;
    end
    else
    begin
      low_prev_q <= low_speed_clk;
      mid_prev_q <= mid_speed_osc;
      high_prev_q <= high_speed_osc;
      meas_prev_q <= measure_input_pin;
    end
  end

  assign low_rise = low_speed_clk && !low_prev_q;
  assign mid_fall = !mid_speed_osc && mid_prev_q;
  assign high_rise = high_speed_osc && !high_prev_q && high_osc_en_q;
  assign meas_rise = measure_input_pin && !meas_prev_q;
  assign meas_evt = meas_run_q && meas_rise;

  // Interval tick: prescaler and 8-bit compare counter
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pre_cnt_q <= '0;
      ival_cnt_q <= '0;
      ival_evt_q <= 1'b0;
    end
    else
    begin
      ival_evt_q <= 1'b0;
      if (low_rise && !reply_active_q)
      begin
        pre_cnt_q <= (pre_cnt_q == PRESCALE_LAST) ? '0 : pre_cnt_q + 1'b1;
        if (pre_cnt_q == PRESCALE_LAST)
        begin
          if (ival_cnt_q == IVAL_COMPARE)
          begin
            ival_cnt_q <= '0;
            ival_evt_q <= 1'b1;
          end
          else
            ival_cnt_q <= ival_cnt_q + 1'b1;
        end
      end
    end
  end

  // Correction sequence
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      stab_cnt_q <= '0;
      high_osc_en_q <= 1'b0;
      sys_clk_high_q <= 1'b0;
      uart_run_q <= 1'b1;
      cal_busy_q <= 1'b0;
      div_start_q <= 1'b0;
    end
    else
    begin
      div_start_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (ival_evt_q && ctrl_en_q)
          begin
            cal_busy_q <= 1'b1;
            state_q <= ST_STOP_UART;
          end
        end
        ST_STOP_UART:
        begin
          uart_run_q <= 1'b0;
          high_osc_en_q <= 1'b1;
          stab_cnt_q <= '0;
          state_q <= ST_STAB;
        end
        ST_STAB:
        begin
          stab_cnt_q <= stab_cnt_q + 1'b1;
          if (stab_cnt_q == STAB_LAST)
            state_q <= ST_SWITCH_HI;
        end
        ST_SWITCH_HI:
        begin
          sys_clk_high_q <= 1'b1;
          state_q <= ST_MEASURE;
        end
        ST_MEASURE:
        begin
          if (meas_evt && evt_cnt_q == MEAS_EVENTS - 2'h1)
          begin
            div_start_q <= 1'b1;
            state_q <= ST_DIVIDE;
          end
        end
        ST_DIVIDE:
        begin
          if (div_done)
            state_q <= ST_WRITE;
        end
        ST_WRITE:
          state_q <= ST_SWITCH_LO;
        ST_SWITCH_LO:
        begin
          sys_clk_high_q <= 1'b0;
          high_osc_en_q <= 1'b0;
          state_q <= ST_RESTART;
        end
        ST_RESTART:
        begin
          uart_run_q <= 1'b1;
          cal_busy_q <= 1'b0;
          state_q <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Waveform channel: down-counter toggling output at zero
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gen_run_q <= 1'b0;
      gen_cnt_q <= '0;
      divided_wave_output <= 1'b0;
    end
    else if (state_q == ST_SWITCH_HI)
    begin
      gen_run_q <= 1'b1;
      gen_cnt_q <= HALF_RELOAD - 16'h0001;
      divided_wave_output <= 1'b0;
    end
    else if (meas_evt && evt_cnt_q == MEAS_EVENTS - 2'h1)
    begin
      gen_run_q <= 1'b0;
      divided_wave_output <= 1'b0;
    end
    else if (gen_run_q && mid_fall)
    begin
      if (gen_cnt_q == 16'h0000)
      begin
        gen_cnt_q <= HALF_RELOAD - 16'h0001;
        divided_wave_output <= !divided_wave_output;
      end
      else
        gen_cnt_q <= gen_cnt_q - 16'h0001;
    end
  end

  // Measuring channel: pulse-width capture between rising edges
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meas_run_q <= 1'b0;
      meas_started_q <= 1'b0;
      meas_cnt_q <= '0;
      cap_q <= '0;
      evt_cnt_q <= '0;
    end
    else if (state_q == ST_SWITCH_HI)
    begin
      meas_run_q <= 1'b1;
      meas_started_q <= 1'b0;
      meas_cnt_q <= '0;
      evt_cnt_q <= '0;
    end
    else if (meas_evt)
    begin
      meas_started_q <= 1'b1;
      meas_cnt_q <= '0;
      cap_q <= meas_cnt_q;
      evt_cnt_q <= evt_cnt_q + 2'h1;
      if (evt_cnt_q == MEAS_EVENTS - 2'h1)
        meas_run_q <= 1'b0;
    end
    else if (meas_started_q && meas_run_q && high_rise && meas_cnt_q != 16'hFFFF)
      meas_cnt_q <= meas_cnt_q + 16'h0001;
  end

  ubc_udiv #(
    .NUM_W(15),
    .DEN_W(8)
  ) u_div (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .start(div_start_q),
    .numerator(FIELD_NUMERATOR),
    .denominator(cap_q[15:8]),
    .done(div_done),
    .quotient(div_quo)
  );

  // Truncated quotient, saturated into the 7-bit field
  assign field_sat = (div_quo > 15'(2 ** FIELD_W - 1)) ? 7'h7F : div_quo[FIELD_W-1:0];

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      uart_divider_reg <= DIVIDER_RESET;
    else if (div_done && cap_q[15:8] != 8'h00)
      uart_divider_reg[15:FIELD_LSB] <= field_sat;
  end

  // Reply request on receive and receive-error events
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reply_start_q <= 1'b0;
      reply_active_q <= 1'b0;
      reply_kind_q <= RP_UNKNOWN;
    end
    else
    begin
      reply_start_q <= 1'b0;
      if (!reply_active_q && rx_error_event)
      begin
        reply_start_q <= 1'b1;
        reply_active_q <= 1'b1;
        reply_kind_q <= (rx_err_kind == ERR_PARITY) ? RP_PARITY :
                        (rx_err_kind == ERR_FRAMING) ? RP_FRAMING : RP_OVERRUN;
      end
      else if (!reply_active_q && rx_complete_event)
      begin
        reply_start_q <= 1'b1;
        reply_active_q <= 1'b1;
        reply_kind_q <= (rx_data == CHAR_UPPER_T) ? RP_OK_UPPER :
                        (rx_data == CHAR_LOWER_T) ? RP_OK_LOWER : RP_UNKNOWN;
      end
      else if (reply_active_q && tx_complete_event)
        reply_active_q <= 1'b0;
    end
  end

  // Register access and interrupt status
  assign wr_clear = bus_req.wr && bus_req.addr == OFS_CLEAR;
  assign wr_enable = bus_req.wr && bus_req.addr == OFS_ENABLE;
  assign wr_ctrl = bus_req.wr && bus_req.addr == OFS_CTRL;
  assign ev_set = {rx_error_event, rx_complete_event, state_q == ST_RESTART, ival_evt_q};

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      status_q <= '0;
      enable_q <= '0;
      ctrl_en_q <= CTRL_RESET_VAL;
      irq_q <= 1'b0;
    end
    else
    begin
      // Set wins over a clear in the same cycle
      status_q <= (status_q & ~(wr_clear ? bus_req.wdata[EV_W-1:0] : '0)) | ev_set;
      if (wr_enable)
        enable_q <= bus_req.wdata[EV_W-1:0];
      if (wr_ctrl)
        ctrl_en_q <= bus_req.wdata[CTRL_CAL_EN];
      irq_q <= |(status_q & enable_q);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      rd_data_q <= '0;
    else if (bus_req.rd)
    begin
      case (bus_req.addr)
        OFS_STATUS: rd_data_q <= DATA_W'(status_q);
        OFS_ENABLE: rd_data_q <= DATA_W'(enable_q);
        OFS_CTRL: rd_data_q <= DATA_W'({cal_busy_q, ctrl_en_q});
        OFS_DIVIDER: rd_data_q <= DATA_W'(uart_divider_reg);
        OFS_CAPTURE: rd_data_q <= DATA_W'(cap_q);
        default: rd_data_q <= RD_UNMAPPED;
      endcase
    end
    else
      rd_data_q <= '0;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  property p_tick_at_compare;
    ival_evt_q |-> $past(ival_cnt_q) == IVAL_COMPARE && ival_cnt_q == 8'h00;
  endproperty
  a_tick_at_compare: assert property (p_tick_at_compare) else $error("tick without compare match");

  property p_halt_in_reply;
    reply_active_q && $past(reply_active_q) |-> $stable(ival_cnt_q) && $stable(pre_cnt_q);
  endproperty
  a_halt_in_reply: assert property (p_halt_in_reply) else $error("interval counter moved in reply");

  property p_wave_toggle;
    gen_run_q && $past(gen_run_q) && $changed(divided_wave_output)
      |-> $past(mid_fall) && $past(gen_cnt_q) == 16'h0000 && gen_cnt_q == HALF_RELOAD - 16'h0001;
  endproperty
  a_wave_toggle: assert property (p_wave_toggle) else $error("wave toggled off schedule");

  property p_no_start_event;
    $rose(gen_run_q) |-> !divided_wave_output ##1 !divided_wave_output;
  endproperty
  a_no_start_event: assert property (p_no_start_event) else $error("output toggled at count start");

  property p_capture;
    meas_evt |=> cap_q == $past(meas_cnt_q) && meas_cnt_q == 16'h0000;
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed on rising edge");

  property p_high_clock_safe;
    sys_clk_high_q |-> high_osc_en_q && !uart_run_q && cal_busy_q;
  endproperty
  a_high_clock_safe: assert property (p_high_clock_safe) else $error("clock high while UART runs");

  property p_stop_after_second;
    state_q == ST_MEASURE && meas_evt && evt_cnt_q == 2'h1
      |=> state_q == ST_DIVIDE && !gen_run_q && !meas_run_q && div_start_q;
  endproperty
  a_stop_after_second: assert property (p_stop_after_second) else $error("channels not stopped");

  property p_divider_update;
    div_done && cap_q[15:8] != 8'h00 |=> uart_divider_reg[15:9] == $past(field_sat);
  endproperty
  a_divider_update: assert property (p_divider_update) else $error("divider field not written");

  property p_keep_on_zero;
    div_done && cap_q[15:8] == 8'h00 |=> $stable(uart_divider_reg);
  endproperty
  a_keep_on_zero: assert property (p_keep_on_zero) else $error("divider changed on zero capture");

  property p_restore;
    state_q == ST_SWITCH_LO |=> !sys_clk_high_q && !high_osc_en_q ##1 uart_run_q && !cal_busy_q;
  endproperty
  a_restore: assert property (p_restore) else $error("clock or UART not restored");

  property p_busy_start;
    $rose(cal_busy_q) |-> $past(ival_evt_q) && $past(state_q) == ST_IDLE;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy raised without tick");

  property p_reply_start;
    !reply_active_q && (rx_complete_event || rx_error_event) |=> reply_start_q && reply_active_q;
  endproperty
  a_reply_start: assert property (p_reply_start) else $error("reply not started");

  c_correction: cover property (state_q == ST_RESTART);
  c_reply_error: cover property (reply_start_q && reply_kind_q == RP_PARITY);
  c_zero_capture: cover property (div_done && cap_q[15:8] == 8'h00);
endmodule

// file: test/ubc_remote_model.sv
// Remote serial device: sends bytes or errors, completes replies
`timescale 1ns/1ns
module ubc_remote_model
  import ubc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic reply_start_q,
  output logic rx_complete_event,
  output logic rx_error_event,
  output logic [7:0] rx_data,
  output logic [1:0] rx_err_kind,
  output logic tx_complete_event
);
  int tx_delay = 20;
  int tx_cnt_q;
  initial
  begin
    rx_complete_event = 1'b0;
    rx_error_event = 1'b0;
    rx_data = 8'h00;
    rx_err_kind = 2'h0;
  end
  // One byte or error, one cycle, then data lines scrambled
  task automatic send(input logic err, input logic [7:0] b);
    @(posedge ref_clk);
    rx_complete_event <= ~err;
    rx_error_event <= err;
    rx_data <= b;
    rx_err_kind <= b[1:0];
    @(posedge ref_clk);
    rx_complete_event <= 1'b0;
    rx_error_event <= 1'b0;
    rx_data <= ~b;
    rx_err_kind <= ~b[1:0];
  endtask
  // Reply characters occupy the line for tx_delay cycles
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_cnt_q <= 0;
      tx_complete_event <= 1'b0;
    end
    else
    begin
      tx_complete_event <= (tx_cnt_q == 1);
      if (reply_start_q)
        tx_cnt_q <= tx_delay;
      else if (tx_cnt_q != 0)
        tx_cnt_q <= tx_cnt_q - 1;
    end
  end
endmodule

// file: test/ubc_calibrator_tb.sv
// Self-checking bench of the baud-rate calibrator
`timescale 1ns/1ns
module ubc_calibrator_tb
  import ubc_pkg::*;
;
  logic ref_clk, sys_rst, low_speed_clk, mid_speed_osc, high_speed_osc;
  logic [1:0] ph;
  ubc_bus_req_t req;
  logic [31:0] rd_data_q, d, cap, e;
  logic irq_q, wave, hso_en, clk_high, uart_run, busy, rx_ev, rxe_ev, tx_ev, rs, ra;
  logic [15:0] div;
  logic [7:0] rx_data;
  logic [1:0] rx_kind;
  ubc_reply_t kind;
  logic [3:0] flg;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  int act = 0;
  int t0;
  logic [8:0] stim [7] = '{9'h054, 9'h074, 9'h041, 9'h100, 9'h101, 9'h102, 9'h103};
  ubc_reply_t exp_k [7] = '{RP_OK_UPPER, RP_OK_LOWER, RP_UNKNOWN, RP_PARITY, RP_FRAMING, RP_OVERRUN, RP_OVERRUN};
  assign flg = {clk_high, busy, ra, irq_q};

  ubc_calibrator uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_req(req), .rd_data_q(rd_data_q),
    .irq_q(irq_q), .low_speed_clk(low_speed_clk), .mid_speed_osc(mid_speed_osc),
    .high_speed_osc(high_speed_osc), .measure_input_pin(wave), .divided_wave_output(wave),
    .high_osc_en_q(hso_en), .sys_clk_high_q(clk_high), .uart_run_q(uart_run), .cal_busy_q(busy),
    .uart_divider_reg(div), .rx_complete_event(rx_ev), .rx_error_event(rxe_ev),
    .tx_complete_event(tx_ev), .rx_data(rx_data), .rx_err_kind(rx_kind), .reply_start_q(rs),
    .reply_active_q(ra), .reply_kind_q(kind));
  ubc_remote_model rem (.ref_clk(ref_clk), .sys_rst(sys_rst), .reply_start_q(rs),
    .rx_complete_event(rx_ev), .rx_error_event(rxe_ev), .rx_data(rx_data), .rx_err_kind(rx_kind),
    .tx_complete_event(tx_ev));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Slow clock, fast osc period 2, mid osc period 4
  always @(posedge ref_clk)
  begin
    low_speed_clk <= ~low_speed_clk;
    high_speed_osc <= ~high_speed_osc;
    ph <= ph + 2'h1;
    mid_speed_osc <= ph[1];
    if (!sys_rst)
    begin
      cyc <= cyc + 1;
      act <= act + int'(ra === 1'b1);
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk_val(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic chk_kind(input string nm, input ubc_reply_t ex, input ubc_reply_t got);
    n_tests++;
    if (got !== ex)
    begin
      miscompares++;
      $display("FAIL %s expected %0d seen %0d", nm, ex, got);
    end
  endtask
  task automatic wait_flag(input int idx, input logic v, input int lim);
    int n;
    n = 0;
    while (flg[idx] !== v && n < lim)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (flg[idx] !== v)
    begin
      miscompares++;
      $display("FAIL wait flag %0d expected %b seen %b", idx, v, flg[idx]);
      end_of_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    req <= {a, v, 1'b1, 1'b0};
    @(posedge ref_clk);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    req <= {a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge ref_clk);
    req <= '0;
    #1;
    v = rd_data_q;
  endtask

  initial
  begin
    sys_rst = 1'b1;
    req = '0;
    low_speed_clk = 1'b0;
    mid_speed_osc = 1'b0;
    high_speed_osc = 1'b0;
    ph = 2'h0;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(OFS_CTRL, d);
    chk_val("ctrl", 32'h0000_0001, d);
    rd(OFS_DIVIDER, d);
    chk_val("divider reset", 32'h0000_CE00, d);
    rd(8'h20, d);
    chk_val("unmapped", RD_UNMAPPED, d);
    wr(OFS_STATUS, 32'h0000_000F);
    rd(OFS_STATUS, d);
    chk_val("status read only", 32'h0000_0000, d);
    $display("test registers done");
    for (int i = 0; i < 7; i++)
    begin
      rem.send(stim[i][8], stim[i][7:0]);
      #1;
      chk_val("reply start", 32'h1, 32'(rs));
      chk_kind("reply kind", exp_k[i], kind);
      if (i == 0)
      begin
        rem.send(1'b0, 8'h74);
        #1;
        chk_val("busy reply start", 32'h0, 32'(rs));
        chk_kind("busy reply kind", RP_OK_UPPER, kind);
      end
      wait_flag(1, 1'b0, 200);
    end
    $display("test replies done");
    // Earlier receptions left status set; start from a clean slate
    wr(OFS_CLEAR, 32'h0000_000F);
    wr(OFS_ENABLE, 32'h0000_0004);
    repeat (2) @(posedge ref_clk);
    #1;
    chk_val("irq idle", 32'h0, 32'(irq_q));
    rem.send(1'b0, 8'h41);
    repeat (3) @(posedge ref_clk);
    #1;
    chk_val("irq raised", 32'h1, 32'(irq_q));
    wr(OFS_ENABLE, 32'h0000_0000);
    repeat (2) @(posedge ref_clk);
    #1;
    chk_val("irq masked", 32'h0, 32'(irq_q));
    wr(OFS_CLEAR, 32'h0000_0004);
    wr(OFS_ENABLE, 32'h0000_0004);
    repeat (2) @(posedge ref_clk);
    #1;
    chk_val("irq cleared", 32'h0, 32'(irq_q));
    wait_flag(1, 1'b0, 200);
    $display("test interrupt done");
    rem.tx_delay = 3000;
    rem.send(1'b0, 8'h54);
    wait_flag(2, 1'b1, 40000);
    chk_val("tick interval", 32'h1, 32'((cyc - act) inside {[29800:30100]}));
    t0 = cyc;
    @(posedge ref_clk);
    #1;
    chk_val("uart stopped", 32'h0, 32'(uart_run));
    chk_val("fast osc on", 32'h1, 32'(hso_en));
    chk_val("clock still mid", 32'h0, 32'(clk_high));
    wait_flag(3, 1'b1, 1100);
    chk_val("settle time", 32'h1, 32'((cyc - t0) inside {[1000:1004]}));
    wait_flag(2, 1'b0, 60000);
    chk_val("uart restarted", 32'h1, 32'(uart_run));
    chk_val("clock back", 32'h0, 32'(clk_high));
    chk_val("fast osc off", 32'h0, 32'(hso_en));
    chk_val("wave stopped", 32'h0, 32'(wave));
    rd(OFS_CAPTURE, cap);
    chk_val("capture", 32'h1, 32'(cap inside {[19030:19034]}));
    e = (cap[15:8] == 8'h00) ? 32'h0000_CE00 : {16'h0000, 7'(((23232 / cap[15:8]) > 127) ? 127 : (23232 / cap[15:8])), 9'h000};
    rd(OFS_DIVIDER, d);
    chk_val("divider", e, d);
    chk_val("divider port", e, 32'(div));
    rd(OFS_STATUS, d);
    chk_val("tick and done", 32'h3, d & 32'h0000_0003);
    $display("test correction done");
    end_of_test();
  end
endmodule
